// ===== design/udma_pkg.sv
// shared constants and types for the micro dma and interrupt request unit
package udma_pkg;
  localparam int NCH = 13;
  localparam int LO_CH = 5;
  localparam int RX_CH = 9;
  localparam logic [3:0] FLAG_OFS = 4'h3;
  localparam logic [15:0] PBLK_BASE = 16'hFF00;
  localparam logic [15:0] ADDR_DMA_EN_LO = 16'hFFE8;
  localparam logic [15:0] ADDR_DMA_EN_HI = 16'hFFE9;
  localparam logic [15:0] ADDR_PEND_LO = 16'hFFEA;
  localparam logic [15:0] ADDR_PEND_HI = 16'hFFEB;
  localparam logic [15:0] ADDR_IEN_LO = 16'hFFF6;
  localparam logic [15:0] ADDR_IEN_HI = 16'hFFF7;
  localparam logic [12:0] FLAGS_RST = 13'h0000;
  localparam logic [2:0] PB_CNT = 3'h0;
  localparam logic [2:0] PB_DST_LO = 3'h1;
  localparam logic [2:0] PB_DST_HI = 3'h2;
  localparam logic [2:0] PB_SRC_LO = 3'h3;
  localparam logic [2:0] PB_SRC_HI = 3'h4;
  localparam logic [2:0] PB_MODE = 3'h5;
  localparam int PB_LEN = 6;
  localparam int MODE_LEN_BIT = 2;
  localparam logic [1:0] UPD_FIX = 2'h0;
  localparam logic [1:0] UPD_DST_INC = 2'h1;
  localparam logic [1:0] UPD_SRC_INC = 2'h2;
  localparam logic [1:0] UPD_SRC_DEC = 2'h3;
  localparam int SVC_STATES = 46;
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 8;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } bus_req_t;

  typedef enum {S_IDLE, S_FREQ, S_FCAP, S_MRD, S_MCAP, S_MWR, S_WB, S_PAD} udma_state_t;
endpackage

// ===== design/sync_fifo.sv
// synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module sync_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // fill side
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  // drain side
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] cnt_reg;
  logic push;
  logic pop;

  assign in_ready_o = cnt_reg != (AW+1)'(DEPTH);
  assign out_valid_o = cnt_reg != '0;
  assign out_data_o = mem[rd_ptr_reg];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_ff @(posedge clk_i)
  begin
    if (push)
    begin
      mem[wr_ptr_reg] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      cnt_reg <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop)
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ===== design/irq_request_bank.sv
// per-channel interrupt request latches
`timescale 1ns/1ps
module irq_request_bank
  import udma_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // set and clear sources
  input wire logic [NCH-1:0] set_i,
  input wire logic [NCH-1:0] ack_clr_i,
  input wire logic [NCH-1:0] sw_clr_i,
  input wire logic rx_read_i,
  // latch state
  output logic [NCH-1:0] pend_o
);
  genvar g;
  generate
    for (g = 0; g < NCH; g++)
    begin : g_latch
      logic clr;
      if (g == RX_CH)
      begin : g_rx
        assign clr = rx_read_i;
      end
      else
      begin : g_std
        assign clr = ack_clr_i[g] || sw_clr_i[g];
      end
      always_ff @(posedge clk_i or negedge rst_b_i)
      begin
        if (!rst_b_i)
          pend_o[g] <= 1'b0;
        else if (set_i[g])
          pend_o[g] <= 1'b1;
        else if (clr)
          pend_o[g] <= 1'b0;
      end
    end
  endgenerate
endmodule

// ===== design/udma_irq_unit.sv
// interrupt request controller with micro dma service engine
`timescale 1ns/1ps
// Summary of operation
// - parameter block starts at FF00h plus the accepted channel vector, six bytes
// - updated addresses and count are written back to their fetch locations
// - count decrements each service; zero continues into vectored handling
// - stored count zero means 256 transfers; eight-bit wrap
// - mode bits 1:0 pick address update, bit 2 picks one or two bytes
// - byte modes: fix, destination +1, source +1, source -1
// - word modes: fix, destination +2, source +2, source -2
// - two-byte move copies src to dst, then src+1 to dst+1
// - source and destination are full sixteen-bit addresses
// - service with nonzero result lasts exactly 46 cycles
// - only memory changes; no cpu register is touched
// - thirteen channels each have request latch, enable and dma flag
// - request pulse is latched until cleared
// - latch clears on reset or on vector acceptance, except the serial receive latch
// - writing vector/8 to Irq_pending_flags_low clears that channel's latch, except the serial receive latch
// - Irq_pending_flags_low/Irq_pending_flags_high read back the request latches, one means pending
// - dma flags at FFE8h/FFE9h route channel to micro dma; reset clears
// - lowest pending enabled vector wins; no compare with running service
// - serial receive latch clears only by reset or buffer read
module udma_irq_unit
  import udma_pkg::*;
(
  // clock and reset
  input wire logic CLK_I,
  input wire logic RST_B_I,
  // peripheral requests
  input wire logic [NCH-1:0] REQ_PULSE_I,
  input wire logic RX_BUF_READ_I,
  // cpu register access
  input wire bus_req_t CPU_ACC_I,
  output logic [7:0] CPU_RDATA_O,
  // cpu interrupt handshake
  input wire logic CPU_ACK_I,
  output logic INT_REQ_O,
  output logic [7:0] VEC_O,
  output logic DMA_BUSY_O,
  output logic GEN_REQ_O,
  output logic [7:0] GEN_VEC_O,
  // memory master
  output bus_req_t MEM_REQ_O,
  input wire logic [7:0] MEM_RDATA_I
);
  udma_state_t state_reg;
  logic [NCH-1:0] pend;
  logic [NCH-1:0] ack_clr;
  logic [NCH-1:0] sw_clr;
  logic [NCH-1:0] dma_en_reg;
  logic [NCH-1:0] ien_reg;
  logic [3:0] vec_ch_reg;
  logic [3:0] win_ch;
  logic win_found;
  logic ack_take;
  logic [5:0] cyc_reg;
  logic [2:0] idx_reg;
  logic bi_reg;
  logic [15:0] base_reg;
  logic [7:0] pb_reg [PB_LEN];
  logic len2;
  logic [15:0] src;
  logic [15:0] dst;
  logic [15:0] step;
  logic [15:0] src_next;
  logic [15:0] dst_next;
  logic [7:0] cnt_next;
  logic [7:0] wb_byte;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [7:0] fifo_out_data;

  function automatic logic [7:0] vec_of(input logic [3:0] ch);
    return {1'b0, ch + FLAG_OFS, 3'h0};
  endfunction

  irq_request_bank u_bank (
    .clk_i(CLK_I),
    .rst_b_i(RST_B_I),
    .set_i(REQ_PULSE_I),
    .ack_clr_i(ack_clr),
    .sw_clr_i(sw_clr),
    .rx_read_i(RX_BUF_READ_I),
    .pend_o(pend)
  );

  // channel clear sources
  assign ack_take = CPU_ACK_I && INT_REQ_O && !DMA_BUSY_O;
  always_comb
  begin
    ack_clr = '0;
    sw_clr = '0;
    if (ack_take)
      ack_clr[vec_ch_reg] = 1'b1;
    if (CPU_ACC_I.wr && CPU_ACC_I.addr == ADDR_PEND_LO && CPU_ACC_I.wdata[7:4] == 4'h0
        && CPU_ACC_I.wdata[3:0] >= FLAG_OFS)
      sw_clr[CPU_ACC_I.wdata[3:0] - FLAG_OFS] = 1'b1;
  end

  // lowest channel index is the highest priority
  always_comb
  begin
    win_found = 1'b0;
    win_ch = 4'h0;
    for (int i = 0; i < NCH; i++)
    begin
      if (!win_found && pend[i] && ien_reg[i])
      begin
        win_found = 1'b1;
        win_ch = 4'(i);
      end
    end
  end
  always_ff @(posedge CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      INT_REQ_O <= 1'b0;
      VEC_O <= 8'h00;
      vec_ch_reg <= 4'h0;
    end
    else
    begin
      INT_REQ_O <= win_found && !ack_take;
      VEC_O <= win_found ? vec_of(win_ch) : 8'h00;
      vec_ch_reg <= win_ch;
    end
  end

  // enable and dma flag registers
  always_ff @(posedge CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      dma_en_reg <= FLAGS_RST;
      ien_reg <= FLAGS_RST;
    end
    else if (CPU_ACC_I.wr)
    begin
      unique case (CPU_ACC_I.addr)
        ADDR_DMA_EN_LO: dma_en_reg <= {dma_en_reg[NCH-1:LO_CH], CPU_ACC_I.wdata[7:3]};
        ADDR_DMA_EN_HI: dma_en_reg <= {CPU_ACC_I.wdata, dma_en_reg[LO_CH-1:0]};
        ADDR_IEN_LO: ien_reg <= {ien_reg[NCH-1:LO_CH], CPU_ACC_I.wdata[7:3]};
        ADDR_IEN_HI: ien_reg <= {CPU_ACC_I.wdata, ien_reg[LO_CH-1:0]};
        default: ;
      endcase
    end
  end
  // register read port, data one cycle after the strobe
  always_ff @(posedge CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
      CPU_RDATA_O <= 8'h00;
    else if (CPU_ACC_I.rd)
    begin
      unique case (CPU_ACC_I.addr)
        ADDR_DMA_EN_LO: CPU_RDATA_O <= {dma_en_reg[LO_CH-1:0], 3'h0};
        ADDR_DMA_EN_HI: CPU_RDATA_O <= dma_en_reg[NCH-1:LO_CH];
        ADDR_PEND_LO: CPU_RDATA_O <= {pend[LO_CH-1:0], 3'h0};
        ADDR_PEND_HI: CPU_RDATA_O <= pend[NCH-1:LO_CH];
        ADDR_IEN_LO: CPU_RDATA_O <= {ien_reg[LO_CH-1:0], 3'h0};
        ADDR_IEN_HI: CPU_RDATA_O <= ien_reg[NCH-1:LO_CH];
        default: CPU_RDATA_O <= 8'h00;
      endcase
    end
  end

  // parameter block fields and their updates
  assign dst = {pb_reg[PB_DST_HI], pb_reg[PB_DST_LO]};
  assign src = {pb_reg[PB_SRC_HI], pb_reg[PB_SRC_LO]};
  assign len2 = pb_reg[PB_MODE][MODE_LEN_BIT];
  assign step = len2 ? 16'h0002 : 16'h0001;
  assign cnt_next = pb_reg[PB_CNT] - 8'h01;
  always_comb
  begin
    src_next = src;
    dst_next = dst;
    unique case (pb_reg[PB_MODE][1:0])
      UPD_FIX: ;
      UPD_DST_INC: dst_next = dst + step;
      UPD_SRC_INC: src_next = src + step;
      UPD_SRC_DEC: src_next = src - step;
    endcase
  end
  always_comb
  begin
    wb_byte = cnt_next;
    unique case (idx_reg)
      PB_DST_LO: wb_byte = dst_next[7:0];
      PB_DST_HI: wb_byte = dst_next[15:8];
      PB_SRC_LO: wb_byte = src_next[7:0];
      PB_SRC_HI: wb_byte = src_next[15:8];
      default: wb_byte = cnt_next;
    endcase
  end
  // moved bytes pass through the fifo on their way to the destination
  assign fifo_in_valid = state_reg == S_MCAP;
  assign fifo_out_ready = state_reg == S_MWR;
  sync_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(CLK_I),
    .rst_b_i(RST_B_I),
    .in_valid_i(fifo_in_valid),
    .in_data_i(MEM_RDATA_I),
    .in_ready_o(fifo_in_ready),
    .out_valid_o(fifo_out_valid),
    .out_data_o(fifo_out_data),
    .out_ready_i(fifo_out_ready)
  );

  // service sequencer; memory is its only target
  always_ff @(posedge CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      state_reg <= S_IDLE;
      cyc_reg <= 6'h00;
      idx_reg <= 3'h0;
      bi_reg <= 1'b0;
      base_reg <= 16'h0000;
      DMA_BUSY_O <= 1'b0;
      GEN_REQ_O <= 1'b0;
      GEN_VEC_O <= 8'h00;
      MEM_REQ_O <= '0;
      for (int i = 0; i < PB_LEN; i++)
        pb_reg[i] <= 8'h00;
    end
    else
    begin
      GEN_REQ_O <= 1'b0;
      MEM_REQ_O <= '0;
      if (DMA_BUSY_O)
        cyc_reg <= cyc_reg + 6'h01;
      unique case (state_reg)
        S_IDLE:
        begin
          cyc_reg <= 6'h00;
          if (ack_take && dma_en_reg[vec_ch_reg])
          begin
            base_reg <= PBLK_BASE + {8'h00, VEC_O};
            MEM_REQ_O.rd <= 1'b1;
            MEM_REQ_O.addr <= PBLK_BASE + {8'h00, VEC_O};
            GEN_VEC_O <= VEC_O;
            idx_reg <= PB_CNT;
            DMA_BUSY_O <= 1'b1;
            state_reg <= S_FREQ;
          end
        end
        S_FREQ: state_reg <= S_FCAP;
        S_FCAP:
        begin
          pb_reg[idx_reg] <= MEM_RDATA_I;
          MEM_REQ_O.rd <= 1'b1;
          if (idx_reg == PB_MODE)
          begin
            MEM_REQ_O.addr <= src;
            bi_reg <= 1'b0;
            state_reg <= S_MRD;
          end
          else
          begin
            MEM_REQ_O.addr <= base_reg + {13'h0000, idx_reg + 3'h1};
            idx_reg <= idx_reg + 3'h1;
            state_reg <= S_FREQ;
          end
        end
        S_MRD: state_reg <= S_MCAP;
        S_MCAP:
        begin
          if (len2 && !bi_reg && fifo_in_ready)
          begin
            MEM_REQ_O.rd <= 1'b1;
            MEM_REQ_O.addr <= src + 16'h0001;
            bi_reg <= 1'b1;
            state_reg <= S_MRD;
          end
          else if (!(len2 && !bi_reg))
          begin
            bi_reg <= 1'b0;
            state_reg <= S_MWR;
          end
        end
        S_MWR:
        begin
          if (fifo_out_valid)
          begin
            MEM_REQ_O.wr <= 1'b1;
            MEM_REQ_O.addr <= dst + {15'h0000, bi_reg};
            MEM_REQ_O.wdata <= fifo_out_data;
            bi_reg <= 1'b1;
            if (!len2 || bi_reg)
            begin
              idx_reg <= PB_CNT;
              state_reg <= S_WB;
            end
          end
        end
        S_WB:
        begin
          MEM_REQ_O.wr <= 1'b1;
          MEM_REQ_O.addr <= base_reg + {13'h0000, idx_reg};
          MEM_REQ_O.wdata <= wb_byte;
          idx_reg <= idx_reg + 3'h1;
          if (idx_reg == PB_SRC_HI)
            state_reg <= S_PAD;
        end
        S_PAD:
        begin
          if (cyc_reg == 6'(SVC_STATES - 1))
          begin
            DMA_BUSY_O <= 1'b0;
            GEN_REQ_O <= cnt_next == 8'h00;
            state_reg <= S_IDLE;
          end
        end
      endcase
    end
  end

  // checks
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RST_B_I);
  a_svc_length: assert property (
    $fell(DMA_BUSY_O) |-> $past(cyc_reg) == 6'(SVC_STATES - 1)
  ) else $error("service length is not 46 cycles");
  a_block_base: assert property (
    $rose(DMA_BUSY_O) |-> MEM_REQ_O.rd && MEM_REQ_O.addr == PBLK_BASE + {8'h00, $past(VEC_O)}
  ) else $error("parameter fetch does not start at block base");
  a_count_wb: assert property (
    DMA_BUSY_O && MEM_REQ_O.wr && $past(state_reg) == S_WB && MEM_REQ_O.addr == base_reg
    |-> MEM_REQ_O.wdata == pb_reg[PB_CNT] - 8'h01
  ) else $error("count written back is not decremented");
  a_gen_on_zero: assert property (
    $fell(DMA_BUSY_O) |-> GEN_REQ_O == (pb_reg[PB_CNT] == 8'h01)
  ) else $error("vectored handoff does not match final count");
  a_mode_kept: assert property (
    DMA_BUSY_O && MEM_REQ_O.wr && $past(state_reg) == S_WB
    |-> MEM_REQ_O.addr != base_reg + 16'h0005
  ) else $error("mode byte overwritten");
  a_rx_no_swclr: assert property (
    pend[RX_CH] && CPU_ACC_I.wr && CPU_ACC_I.addr == ADDR_PEND_LO && !RX_BUF_READ_I
    |=> pend[RX_CH]
  ) else $error("serial receive latch cleared by write");
  a_sw_clear: assert property (
    CPU_ACC_I.wr && CPU_ACC_I.addr == ADDR_PEND_LO && CPU_ACC_I.wdata == 8'h03
    && !REQ_PULSE_I[0] |=> !pend[0]
  ) else $error("write of vector/8 did not clear latch");
  a_req_latched: assert property (
    REQ_PULSE_I[2] |=> pend[2] [*2] or (pend[2] ##1 !pend[2])
  ) else $error("request pulse not latched");
  a_ack_clear: assert property (
    ack_take && vec_ch_reg == 4'h1 && !REQ_PULSE_I[1] |=> !pend[1]
  ) else $error("accepted channel latch not cleared");
  a_prio_lowest: assert property (
    $past(pend[1] && ien_reg[1] && !(pend[0] && ien_reg[0])) |-> VEC_O == 8'h20
  ) else $error("lowest pending vector did not win");
  c_dma_nonzero: cover property ($fell(DMA_BUSY_O) && !GEN_REQ_O);
  c_dma_handoff: cover property (GEN_REQ_O);
  c_two_byte: cover property (DMA_BUSY_O && len2 && state_reg == S_MWR);
  c_plain_ack: cover property (ack_take && !dma_en_reg[vec_ch_reg]);
endmodule

// ===== dv/ram_model.sv
// synchronous byte memory answering the memory master
`timescale 1ns/1ps
module ram_model
  import udma_pkg::*;
(
  // clock
  input wire logic clk_i,
  // memory port
  input wire bus_req_t req_i,
  output logic [7:0] rdata_o
);
  logic [7:0] mem [0:65535];
  initial rdata_o = 8'h00;
  // data valid only in the cycle after a read; otherwise it keeps toggling
  always @(posedge clk_i)
  begin
    if (req_i.rd)
      rdata_o <= mem[req_i.addr];
    else
      rdata_o <= ~rdata_o;
    if (req_i.wr)
      mem[req_i.addr] <= req_i.wdata;
  end
endmodule

// ===== dv/udma_irq_unit_tb.sv
// self-checking bench for the micro dma and interrupt request unit
`timescale 1ns/1ps
module udma_irq_unit_tb;
  import udma_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [NCH-1:0] req = '0;
  logic rx_rd = 1'b0;
  bus_req_t acc = '0;
  logic ack = 1'b0;
  logic [7:0] rdata, vec, gen_vec, mem_rdata;
  logic int_req, busy, gen_req;
  bus_req_t mem_req;
  int err_total = 0;
  int cmp_count = 0;
  always #25 clk = ~clk;
  udma_irq_unit u_dut (.CLK_I(clk), .RST_B_I(rst_b), .REQ_PULSE_I(req), .RX_BUF_READ_I(rx_rd),
    .CPU_ACC_I(acc), .CPU_RDATA_O(rdata), .CPU_ACK_I(ack), .INT_REQ_O(int_req), .VEC_O(vec),
    .DMA_BUSY_O(busy), .GEN_REQ_O(gen_req), .GEN_VEC_O(gen_vec), .MEM_REQ_O(mem_req),
    .MEM_RDATA_I(mem_rdata));
  ram_model u_ram (.clk_i(clk), .req_i(mem_req), .rdata_o(mem_rdata));

  task automatic test_done();
    if (err_total == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
    acc <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(negedge clk);
    acc <= '0;
    @(negedge clk);
  endtask
  task automatic reg_rd(input logic [15:0] a, input logic [7:0] e);
    acc <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(negedge clk);
    acc <= '0;
    chk({8'h00, rdata}, {8'h00, e});
    @(negedge clk);
  endtask
  task automatic pulse(input logic [NCH-1:0] m);
    req <= m;
    @(negedge clk);
    req <= '0;
    @(negedge clk);
  endtask
  // wait for a request, then accept it for one cycle
  task automatic take(input logic [7:0] e);
    int n;
    n = 0;
    while (int_req !== 1'b1)
    begin
      @(negedge clk);
      n++;
      if (n > 20)
      begin
        err_total++;
        test_done();
      end
    end
    chk({8'h00, vec}, {8'h00, e});
    ack <= 1'b1;
    @(negedge clk);
    ack <= 1'b0;
  endtask

  task automatic t_reset();
    reg_rd(ADDR_PEND_LO, 8'h00);
    reg_rd(ADDR_PEND_HI, 8'h00);
    reg_rd(ADDR_DMA_EN_LO, 8'h00);
    reg_rd(16'hFFE0, 8'h00);
    // mid-run reset with latches and flags set
    pulse(13'h1FFF);
    reg_wr(ADDR_DMA_EN_HI, 8'hFF);
    reg_wr(ADDR_IEN_LO, 8'hF8);
    reg_rd(ADDR_DMA_EN_HI, 8'hFF);
    reg_rd(ADDR_PEND_HI, 8'hFF);
    rst_b <= 1'b0;
    repeat (2) @(negedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    chk({15'h0000, int_req}, 16'h0000);
    reg_rd(ADDR_PEND_LO, 8'h00);
    reg_rd(ADDR_PEND_HI, 8'h00);
    reg_rd(ADDR_DMA_EN_HI, 8'h00);
    reg_rd(ADDR_IEN_LO, 8'h00);
  endtask
  task automatic t_latch();
    pulse(13'h0004);
    reg_rd(ADDR_PEND_LO, 8'h20);
    reg_wr(ADDR_PEND_HI, 8'h05);
    reg_rd(ADDR_PEND_LO, 8'h20);
    reg_wr(ADDR_PEND_LO, 8'h05);
    reg_rd(ADDR_PEND_LO, 8'h00);
    pulse(13'h0040);
    reg_rd(ADDR_PEND_HI, 8'h02);
    reg_wr(ADDR_PEND_LO, 8'h09);
    reg_rd(ADDR_PEND_HI, 8'h00);
    pulse(13'h1FFF);
    reg_rd(ADDR_PEND_LO, 8'hF8);
    reg_rd(ADDR_PEND_HI, 8'hFF);
    chk({15'h0000, int_req}, 16'h0000);
    for (int i = 0; i < NCH; i++)
      reg_wr(ADDR_PEND_LO, 8'(i + 3));
    reg_rd(ADDR_PEND_HI, 8'h10);
    rx_rd <= 1'b1;
    @(negedge clk);
    rx_rd <= 1'b0;
    @(negedge clk);
    reg_rd(ADDR_PEND_LO, 8'h00);
    reg_rd(ADDR_PEND_HI, 8'h00);
  endtask
  task automatic t_prio();
    reg_wr(ADDR_IEN_LO, 8'h50);
    pulse(13'h000A);
    take(8'h20);
    @(negedge clk);
    reg_rd(ADDR_PEND_LO, 8'h40);
    take(8'h30);
    @(negedge clk);
    reg_rd(ADDR_PEND_LO, 8'h00);
    chk({15'h0000, int_req}, 16'h0000);
    reg_wr(ADDR_IEN_LO, 8'h00);
  endtask
  // one service on channel 0 with its block at FF18
  task automatic t_svc(input logic [2:0] md, input logic [7:0] cnt,
    input logic [15:0] src, input logic [15:0] dst, input logic gen);
    logic [15:0] len, dn, sn, b;
    int n;
    b = PBLK_BASE + 16'h0018;
    len = md[2] ? 16'h0002 : 16'h0001;
    dn = (md[1:0] == UPD_DST_INC) ? dst + len : dst;
    sn = (md[1:0] == UPD_SRC_INC) ? src + len : (md[1:0] == UPD_SRC_DEC) ? src - len : src;
    {u_ram.mem[b], u_ram.mem[b + 1], u_ram.mem[b + 2]} = {cnt, dst[7:0], dst[15:8]};
    {u_ram.mem[b + 3], u_ram.mem[b + 4], u_ram.mem[b + 5]} = {src[7:0], src[15:8], 5'h00, md};
    {u_ram.mem[src], u_ram.mem[src + 1]} = 16'hA55A;
    {u_ram.mem[dst], u_ram.mem[dst + 1]} = 16'h0000;
    pulse(13'h0001);
    take(8'h18);
    n = 0;
    while (busy === 1'b1)
    begin
      @(negedge clk);
      n++;
      if (n > 100)
      begin
        err_total++;
        test_done();
      end
    end
    if (!gen)
      chk(16'(n), 16'(SVC_STATES));
    chk({15'h0000, gen_req}, {15'h0000, gen});
    if (gen)
      chk({8'h00, gen_vec}, 16'h0018);
    chk({8'h00, u_ram.mem[b]}, {8'h00, cnt - 8'h01});
    chk({u_ram.mem[b + 2], u_ram.mem[b + 1]}, dn);
    chk({u_ram.mem[b + 4], u_ram.mem[b + 3]}, sn);
    chk({u_ram.mem[dst], u_ram.mem[dst + 1]}, md[2] ? 16'hA55A : 16'hA500);
    chk({8'h00, u_ram.mem[b + 5]}, {13'h0000, md});
  endtask

  initial
  begin
    repeat (20) @(negedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    t_reset();
    t_latch();
    t_prio();
    reg_wr(ADDR_IEN_LO, 8'h08);
    reg_wr(ADDR_DMA_EN_LO, 8'h08);
    reg_rd(ADDR_DMA_EN_LO, 8'h08);
    // all eight modes, one and two bytes, count 2 so no vectored handoff
    for (int m = 0; m < 8; m++)
      t_svc(3'(m), 8'h02, 16'h8000 + 16'(m * 16), 16'h4000 + 16'(m * 16), 1'b0);
    t_svc(3'h1, 8'h01, 16'h9000, 16'h5000, 1'b1);
    t_svc(3'h7, 8'h00, 16'hFFFE, 16'h0000, 1'b0);
    test_done();
  end
endmodule
